// ### rtl/ssag_defines.svh
`ifndef SSAG_DEFINES_SVH
`define SSAG_DEFINES_SVH

// register encodings {crn, crm, opc2} of coprocessor writes and reads
`define SSAG_ENC_SYSCTL   {4'h1, 4'h0, 3'h0}
`define SSAG_ENC_AUXCTL   {4'h1, 4'h0, 3'h1}
`define SSAG_ENC_SECCFG   {4'h1, 4'h1, 3'h0}
`define SSAG_ENC_TBASE0   {4'h2, 4'h0, 3'h0}
`define SSAG_ENC_TBCTL    {4'h2, 4'h0, 3'h2}
`define SSAG_ENC_DOMAIN   {4'h3, 4'h0, 3'h0}
`define SSAG_ENC_PRIMAP   {4'hA, 4'h2, 3'h0}
`define SSAG_ENC_NORMAP   {4'hA, 4'h2, 3'h1}
`define SSAG_ENC_VECBASE  {4'hC, 4'h0, 3'h0}
`define SSAG_ENC_MONVEC   {4'hC, 4'h0, 3'h1}

// storage slot of each register
`define SSAG_IDX_SYSCTL   4'h0
`define SSAG_IDX_AUXCTL   4'h1
`define SSAG_IDX_TBASE0   4'h2
`define SSAG_IDX_TBCTL    4'h3
`define SSAG_IDX_DOMAIN   4'h4
`define SSAG_IDX_PRIMAP   4'h5
`define SSAG_IDX_NORMAP   4'h6
`define SSAG_IDX_VECBASE  4'h7
`define SSAG_IDX_MONVEC   4'h8
`define SSAG_IDX_SECCFG   4'h9
`define SSAG_NUM_REGS     10

// field position of the select bit inside the secure configuration reg
`define SSAG_NSBIT_POS    0

// processor mode codes and reset values
`define SSAG_MODE_USR     5'h10
`define SSAG_MODE_SVC     5'h13
`define SSAG_MODE_MON     5'h16
`define SSAG_RST_MODE     5'h13
`define SSAG_RST_NSBIT    1'b0
`define SSAG_RST_VAL      32'h0000_0000

`endif

// ### rtl/ssag_pkg.sv
package ssag_pkg;

  // security class of a system register
  typedef enum logic [1:0] {
    SSAG_CLS_COMMON,
    SSAG_CLS_BANKED,
    SSAG_CLS_SECURE
  } ssag_class_t;

endpackage

// ### rtl/ssag_reg_decode.sv
`timescale 1ns/10ps
`include "ssag_defines.svh"

module ssag_reg_decode (
  input  wire logic                [3:0] crn_in,
  input  wire logic                [3:0] crm_in,
  input  wire logic                [2:0] opc2_in,
  output logic                           hit_out,
  output logic                     [3:0] idx_out,
  output ssag_pkg::ssag_class_t          class_out,
  output logic                           protect_out
);
  import ssag_pkg::*;

  // pure decode of the register encoding, no state
  always_comb begin
    hit_out     = 1'b1;
    idx_out     = `SSAG_IDX_SYSCTL;
    class_out   = SSAG_CLS_BANKED;
    protect_out = 1'b1;
    case ({crn_in, crm_in, opc2_in})
      `SSAG_ENC_SYSCTL: idx_out = `SSAG_IDX_SYSCTL;
      `SSAG_ENC_AUXCTL: begin
        idx_out   = `SSAG_IDX_AUXCTL;
        class_out = SSAG_CLS_COMMON;
      end
      `SSAG_ENC_TBASE0:  idx_out = `SSAG_IDX_TBASE0;
      `SSAG_ENC_TBCTL:   idx_out = `SSAG_IDX_TBCTL;
      `SSAG_ENC_DOMAIN:  idx_out = `SSAG_IDX_DOMAIN;
      `SSAG_ENC_PRIMAP:  idx_out = `SSAG_IDX_PRIMAP;
      `SSAG_ENC_NORMAP:  idx_out = `SSAG_IDX_NORMAP;
      `SSAG_ENC_VECBASE: idx_out = `SSAG_IDX_VECBASE;
      `SSAG_ENC_MONVEC: begin
        idx_out   = `SSAG_IDX_MONVEC;
        class_out = SSAG_CLS_SECURE;
      end
      `SSAG_ENC_SECCFG: begin
        // configuration reg itself is not in the lockable set
        idx_out     = `SSAG_IDX_SECCFG;
        class_out   = SSAG_CLS_SECURE;
        protect_out = 1'b0;
      end
      default: begin
        hit_out     = 1'b0;
        protect_out = 1'b0;
        class_out   = SSAG_CLS_COMMON;
      end
    endcase
  end

endmodule

// ### rtl/ssag_access_guard.sv
`timescale 1ns/10ps
`include "ssag_defines.svh"

// How it works
// R01: locked writes to protected registers raise undefined
// R02: system and auxiliary control writes are lockable
// R03: table base zero and control are lockable
// R04: domain access register write is lockable
// R05: both memory remap registers are lockable
// R06: exception vector base register is lockable
// R07: monitor vector base register is lockable
// R08: soc holds lock low during reset
// R09: lock change acts on next decoded access
// R10: registers are secure-only, banked or common
// R11: monitor mode accesses are always secure
// R12: in monitor, select bit picks banked copy
// R13: monitor always reaches secure-only registers
// R14: reads of locked registers still complete
// R15: reset gives supervisor, secure, select bit zero
// R16: outside monitor, security state picks copy
// R17: locked non-secure banked copy writes proceed

module ssag_access_guard #(
  parameter int DATA_W = 32
) (
  input  wire logic                   clock_in,
  input  wire logic                   resetn_in,
  input  wire logic                   secure_write_lock_in,
  input  wire logic                   req_valid_in,
  input  wire logic                   req_write_in,
  input  wire logic             [2:0] req_opc1_in,
  input  wire logic             [3:0] req_crn_in,
  input  wire logic             [3:0] req_crm_in,
  input  wire logic             [2:0] req_opc2_in,
  input  wire logic      [DATA_W-1:0] req_wdata_in,
  input  wire logic                   mode_wr_in,
  input  wire logic             [4:0] mode_in,
  output logic                        resp_valid_out,
  output logic                        resp_undef_out,
  output logic           [DATA_W-1:0] resp_rdata_out,
  output logic                        resp_secure_copy_out,
  output ssag_pkg::ssag_class_t       resp_class_out,
  output logic                        nonsecure_select_bit_out,
  output logic                  [4:0] cpu_mode_out
);
  import ssag_pkg::*;

  logic              dec_hit;
  logic        [3:0] dec_idx;
  ssag_class_t       dec_cls;
  logic              dec_prot;

  // register copies: secure (also common) and non-secure banked
  logic [DATA_W-1:0] sec_q [`SSAG_NUM_REGS];
  logic [DATA_W-1:0] sec_d [`SSAG_NUM_REGS];
  logic [DATA_W-1:0] nsc_q [`SSAG_NUM_REGS];
  logic [DATA_W-1:0] nsc_d [`SSAG_NUM_REGS];

  logic        [4:0] mode_q;
  logic        [4:0] mode_d;
  logic              ns_q;
  logic              ns_d;
  logic              vld_q;
  logic              vld_d;
  logic              undef_q;
  logic              undef_d;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic              secsel_q;
  logic              secsel_d;
  ssag_class_t       cls_q;
  ssag_class_t       cls_d;

  logic              monitor;
  logic              secure_state;
  logic              use_sec;
  logic              privileged;
  logic              lock_hit;

  ssag_reg_decode u_decode (
    .crn_in      (req_crn_in),
    .crm_in      (req_crm_in),
    .opc2_in     (req_opc2_in),
    .hit_out     (dec_hit),
    .idx_out     (dec_idx),
    .class_out   (dec_cls),
    .protect_out (dec_prot)
  );

  // security view of the current access
  always_comb begin
    monitor      = (mode_q == `SSAG_MODE_MON);
    secure_state = monitor | ~ns_q;                        // R11
    // monitor: select bit picks the copy; elsewhere the state does,
    // and both collapse to the inverted select bit
    use_sec      = (dec_cls != SSAG_CLS_BANKED) | ~ns_q;   // R12 R16
    privileged   = (mode_q != `SSAG_MODE_USR);
    // lock is used unregistered so the very next access sees it
    lock_hit     = req_write_in & secure_write_lock_in & dec_prot & use_sec; // R01 R09 R17
  end

  // next values of the bank, mode, select bit and response
  always_comb begin
    sec_d    = sec_q;
    nsc_d    = nsc_q;
    mode_d   = mode_q;
    ns_d     = ns_q;
    vld_d    = req_valid_in;
    undef_d  = 1'b0;
    rdata_d  = '0;
    secsel_d = 1'b0;
    cls_d    = SSAG_CLS_COMMON;
    // mode change is seen by accesses from the next cycle on
    if (mode_wr_in) begin
      mode_d = mode_in;
    end
    if (req_valid_in) begin
      cls_d    = dec_cls;                                  // R10
      secsel_d = use_sec;
      if (!dec_hit || (req_opc1_in != 3'h0) || !privileged) begin
        undef_d = 1'b1;
      end else if (dec_cls == SSAG_CLS_SECURE && !secure_state) begin
        undef_d = 1'b1;                                    // R10 R13
      end else if (lock_hit) begin
        undef_d = 1'b1;                                    // R01 R02 R03 R04 R05 R06 R07
      end else if (req_write_in) begin
        if (use_sec) begin
          sec_d[dec_idx] = req_wdata_in;
        end else begin
          nsc_d[dec_idx] = req_wdata_in;                   // R17
        end
        if (dec_idx == `SSAG_IDX_SECCFG) begin
          ns_d = req_wdata_in[`SSAG_NSBIT_POS];
        end
      end else begin
        // reads go through even under lock
        rdata_d = use_sec ? sec_q[dec_idx] : nsc_q[dec_idx]; // R14
      end
    end
  end

  // registers only; reset puts the core in secure supervisor state
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `SSAG_NUM_REGS; i++) begin
        sec_q[i] <= `SSAG_RST_VAL;
        nsc_q[i] <= `SSAG_RST_VAL;
      end
      mode_q   <= `SSAG_RST_MODE;                          // R15
      ns_q     <= `SSAG_RST_NSBIT;                         // R15
      vld_q    <= 1'b0;
      undef_q  <= 1'b0;
      rdata_q  <= '0;
      secsel_q <= 1'b0;
      cls_q    <= SSAG_CLS_COMMON;
    end else begin
      sec_q    <= sec_d;
      nsc_q    <= nsc_d;
      mode_q   <= mode_d;
      ns_q     <= ns_d;
      vld_q    <= vld_d;
      undef_q  <= undef_d;
      rdata_q  <= rdata_d;
      secsel_q <= secsel_d;
      cls_q    <= cls_d;
    end
  end

  // every output straight from a flip-flop
  assign resp_valid_out           = vld_q;
  assign resp_undef_out           = undef_q;
  assign resp_rdata_out           = rdata_q;
  assign resp_secure_copy_out     = secsel_q;
  assign resp_class_out           = cls_q;
  assign nonsecure_select_bit_out = ns_q;
  assign cpu_mode_out             = mode_q;

  // helper terms for the checks below
  logic [10:0] chk_enc;
  logic        chk_lkw;
  logic        chk_sec_wr;
  logic        rst_seen_q;
  logic        rst_seen_d;
  assign chk_enc    = {req_crn_in, req_crm_in, req_opc2_in};
  // chk_lkw: a legal write from the secure side while locked
  assign chk_lkw    = req_valid_in & req_write_in & secure_write_lock_in
                      & privileged & (req_opc1_in == 3'h0) & ~ns_q;
  assign chk_sec_wr = chk_lkw | (req_valid_in & req_write_in & privileged
                      & (req_opc1_in == 3'h0) & ~ns_q);

  // remembers that reset was just released
  always_comb begin
    rst_seen_d = ~resetn_in;
  end

  // registered copy, read by the reset check only
  always_ff @(posedge clock_in) begin
    rst_seen_q <= rst_seen_d;
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  // lock refusals: any protected write, then group by group
  a_lock_any_prot: assert property ( // R01
    req_valid_in && lock_hit |=> resp_undef_out && resp_valid_out)
    else $error("locked protected write did not raise undefined");

  a_lock_sysctl_aux: assert property ( // R02
    chk_lkw && (chk_enc == `SSAG_ENC_SYSCTL || chk_enc == `SSAG_ENC_AUXCTL)
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_SYSCTL])
        && $stable(sec_q[`SSAG_IDX_AUXCTL]))
    else $error("locked control register write changed state");

  a_lock_tbase: assert property ( // R03
    chk_lkw && (chk_enc == `SSAG_ENC_TBASE0 || chk_enc == `SSAG_ENC_TBCTL)
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_TBASE0])
        && $stable(sec_q[`SSAG_IDX_TBCTL]))
    else $error("locked table base write not refused");

  a_lock_domain: assert property ( // R04
    chk_lkw && chk_enc == `SSAG_ENC_DOMAIN
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_DOMAIN]))
    else $error("locked domain access write not refused");

  a_lock_remap: assert property ( // R05
    chk_lkw && (chk_enc == `SSAG_ENC_PRIMAP || chk_enc == `SSAG_ENC_NORMAP)
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_PRIMAP])
        && $stable(sec_q[`SSAG_IDX_NORMAP]))
    else $error("locked remap write not refused");

  a_lock_vecbase: assert property ( // R06
    chk_lkw && chk_enc == `SSAG_ENC_VECBASE
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_VECBASE]))
    else $error("locked vector base write not refused");

  a_lock_monvec: assert property ( // R07
    chk_lkw && chk_enc == `SSAG_ENC_MONVEC
    |=> resp_undef_out && $stable(sec_q[`SSAG_IDX_MONVEC]))
    else $error("locked monitor vector write not refused");

  // with the lock low a secure-side write lands in the next cycle
  a_unlock_next: assert property ( // R09
    chk_sec_wr && !secure_write_lock_in && dec_hit
    && (dec_cls != SSAG_CLS_SECURE || secure_state)
    |=> !resp_undef_out ##0 sec_q[$past(dec_idx)] == $past(req_wdata_in))
    else $error("unlocked write was not applied on the next cycle");

  // security classes and the choice of banked copy
  a_secure_only_ns: assert property ( // R10
    req_valid_in && dec_cls == SSAG_CLS_SECURE && !monitor && ns_q
    |=> resp_undef_out && resp_class_out == SSAG_CLS_SECURE)
    else $error("non-secure access to secure-only register allowed");

  a_monitor_secure: assert property ( // R11 R13
    req_valid_in && monitor && !req_write_in && dec_hit
    && req_opc1_in == 3'h0 |=> !resp_undef_out)
    else $error("monitor mode read refused");

  a_monitor_bank: assert property ( // R12
    req_valid_in && monitor && dec_cls == SSAG_CLS_BANKED
    |=> resp_secure_copy_out == !$past(ns_q))
    else $error("monitor mode picked the wrong banked copy");

  // the lock never refuses a read
  a_locked_read: assert property ( // R14
    req_valid_in && !req_write_in && secure_write_lock_in && dec_prot
    && privileged && req_opc1_in == 3'h0 && dec_cls != SSAG_CLS_SECURE
    |=> !resp_undef_out ##0 resp_valid_out)
    else $error("read of a locked register was refused");

  // reset state and response timing
  a_reset_state: assert property ( // R15
    rst_seen_q |-> mode_q == `SSAG_MODE_SVC && !ns_q)
    else $error("reset did not leave secure supervisor state");

  a_resp_pulse: assert property ( // R10
    req_valid_in |=> resp_valid_out)
    else $error("request got no response in the next cycle");

  a_resp_idle: assert property ( // R10
    !req_valid_in |=> !resp_valid_out && !resp_undef_out)
    else $error("response raised without a request");

  a_state_bank: assert property ( // R16
    req_valid_in && !monitor && dec_cls == SSAG_CLS_BANKED
    |=> resp_secure_copy_out == $past(secure_state))
    else $error("security state picked the wrong banked copy");

  // non-secure copies stay writable while locked
  a_ns_copy_write: assert property ( // R17
    req_valid_in && req_write_in && secure_write_lock_in && ns_q
    && privileged && req_opc1_in == 3'h0 && dec_cls == SSAG_CLS_BANKED
    |=> !resp_undef_out ##0 nsc_q[$past(dec_idx)] == $past(req_wdata_in))
    else $error("non-secure copy write under lock was refused");

  a_lock_ns_monitor: assert property ( // R12 R17
    req_valid_in && req_write_in && monitor && ns_q && secure_write_lock_in
    && req_opc1_in == 3'h0 && dec_cls == SSAG_CLS_BANKED
    |=> !resp_undef_out && !resp_secure_copy_out)
    else $error("monitor write to non-secure copy refused under lock");

  // main scenarios that the bench should reach
  c_lock_refusal: cover property (chk_lkw && dec_prot ##1 resp_undef_out);
  c_monitor_lock_ns: cover property (
    req_valid_in && req_write_in && monitor && ns_q && secure_write_lock_in);
  c_ns_bank_write: cover property (
    req_valid_in && req_write_in && ns_q && dec_cls == SSAG_CLS_BANKED);
  c_monitor_ns1: cover property (req_valid_in && monitor && ns_q);
  c_lock_toggle: cover property (secure_write_lock_in ##1 !secure_write_lock_in);

endmodule

// ### sim/ssag_lock_src.sv
`timescale 1ns/10ps

// soc-side source of the write lock, loaded on request from the bench
module ssag_lock_src (
  input  wire logic clock_in,
  input  wire logic resetn_in,
  input  wire logic lock_req_in,
  output logic      lock_out
);
  logic lock_q;
  logic lock_d;

  // next value: the wanted level, cleared in reset
  always_comb begin
    lock_d = resetn_in ? lock_req_in : 1'b0;
  end

  // lock held in a flop so it only moves right after an edge
  always_ff @(posedge clock_in) begin
    lock_q <= lock_d;
  end

  // gated by reset so the pin is low before the first edge too
  assign lock_out = resetn_in & lock_q;
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
`include "ssag_defines.svh"

module tb;
  import ssag_pkg::*;
  localparam logic [10:0] ENC_TAB [10] = '{`SSAG_ENC_SYSCTL, `SSAG_ENC_AUXCTL,
    `SSAG_ENC_TBASE0, `SSAG_ENC_TBCTL, `SSAG_ENC_DOMAIN, `SSAG_ENC_PRIMAP,
    `SSAG_ENC_NORMAP, `SSAG_ENC_VECBASE, `SSAG_ENC_MONVEC, `SSAG_ENC_SECCFG};
  localparam ssag_class_t CLS_TAB [10] = '{SSAG_CLS_BANKED, SSAG_CLS_COMMON,
    SSAG_CLS_BANKED, SSAG_CLS_BANKED, SSAG_CLS_BANKED, SSAG_CLS_BANKED,
    SSAG_CLS_BANKED, SSAG_CLS_BANKED, SSAG_CLS_SECURE, SSAG_CLS_SECURE};
  localparam logic [9:0] PROT_TAB = 10'h1FF;

  logic        clock_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        lock_req = 1'b0;
  logic        lock;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [2:0]  req_opc1 = 3'h0;
  logic [10:0] req_enc = 11'h000;
  logic [31:0] req_wdata = 32'h0;
  logic        mode_wr = 1'b0;
  logic [4:0]  mode = 5'h13;
  logic        resp_valid, resp_undef, resp_sc, ns_bit;
  logic [31:0] resp_rdata;
  ssag_class_t resp_class;
  logic [4:0]  cpu_mode;
  logic [4:0]  m_mode;
  logic        m_ns, m_lock;
  logic [31:0] mem [10][2];
  int          n_errors = 0;
  int          tests_run = 0;
  logic [31:0] r;

  always #12.5 clock_in = ~clock_in;

  ssag_lock_src u_ssag_lock_src (.clock_in(clock_in), .resetn_in(resetn_in),
    .lock_req_in(lock_req), .lock_out(lock));

  ssag_access_guard u_ssag_access_guard (.clock_in(clock_in), .resetn_in(resetn_in),
    .secure_write_lock_in(lock), .req_valid_in(req_valid), .req_write_in(req_write),
    .req_opc1_in(req_opc1), .req_crn_in(req_enc[10:7]), .req_crm_in(req_enc[6:3]),
    .req_opc2_in(req_enc[2:0]), .req_wdata_in(req_wdata), .mode_wr_in(mode_wr),
    .mode_in(mode), .resp_valid_out(resp_valid), .resp_undef_out(resp_undef),
    .resp_rdata_out(resp_rdata), .resp_secure_copy_out(resp_sc),
    .resp_class_out(resp_class), .nonsecure_select_bit_out(ns_bit),
    .cpu_mode_out(cpu_mode));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // banked copy follows the select bit in every mode
  function automatic logic exp_copy(input int k);
    return (CLS_TAB[k] == SSAG_CLS_BANKED) ? ~m_ns : 1'b1;
  endfunction

  function automatic logic exp_undef(input logic wr, input logic [2:0] o1, input int k);
    if (k < 0 || o1 != 3'h0 || m_mode == `SSAG_MODE_USR) return 1'b1;
    if (CLS_TAB[k] == SSAG_CLS_SECURE && m_ns && m_mode != `SSAG_MODE_MON)
      return 1'b1;
    return wr & m_lock & PROT_TAB[k] & exp_copy(k);
  endfunction

  // reset with the model cleared; lock is dropped first
  task automatic do_reset();
    req_valid = 1'b0;
    lock_req = 1'b0;
    resetn_in = 1'b0;
    m_mode = `SSAG_MODE_SVC;
    m_ns = 1'b0;
    m_lock = 1'b0;
    foreach (mem[i, j]) mem[i][j] = 32'h0;
    repeat (8) @(posedge clock_in);
    #1;
    chk(32'(cpu_mode), 32'(`SSAG_MODE_SVC));
    chk(32'(ns_bit), 32'h0);
    chk(32'(resp_valid), 32'h0);
    resetn_in = 1'b1;
  endtask

  task automatic set_mode(input logic [4:0] m);
    req_valid = 1'b0;
    mode_wr = 1'b1;
    mode = m;
    @(posedge clock_in);
    #1;
    mode_wr = 1'b0;
    m_mode = m;
    chk(32'(cpu_mode), 32'(m));
  endtask

  // lock is live from the first cycle after this returns
  task automatic set_lock(input logic v);
    req_valid = 1'b0;
    lock_req = v;
    @(posedge clock_in);
    #1;
    m_lock = v;
  endtask

  task automatic acc(input logic wr, input logic [2:0] o1, input logic [10:0] enc,
                     input logic [31:0] wd);
    int k;
    logic und, sc;
    logic [31:0] rd;
    k = -1;
    for (int i = 0; i < 10; i++) if (ENC_TAB[i] === enc) k = i;
    und = exp_undef(wr, o1, k);
    sc = (k >= 0) ? exp_copy(k) : 1'b1;
    rd = (!und && !wr) ? mem[k][sc] : 32'h0;
    req_valid = 1'b1;
    req_write = wr;
    req_opc1 = o1;
    req_enc = enc;
    req_wdata = wd;
    // valid stays up so back-to-back accesses need no extra edge
    @(posedge clock_in);
    #1;
    chk(32'(resp_valid), 32'h1);
    chk(32'(resp_undef), 32'(und));
    chk(resp_rdata, rd);
    if (k >= 0) begin
      chk(32'(resp_sc), 32'(sc));
      chk(32'(resp_class), 32'(CLS_TAB[k]));
      if (!und && wr) mem[k][sc] = wd;
      if (!und && wr && k == 9) m_ns = wd[0];
    end
  endtask

  initial begin
    #100000;
    n_errors++;
    print_verdict();
  end

  initial begin
    void'($urandom(33513));
    do_reset();
    // even data keeps the select bit clear, so the locked pass hits secure copies
    for (int k = 0; k < 10; k++) acc(1'b1, 3'h0, ENC_TAB[k], 32'hA5A5_0000 + 2 * k);
    set_lock(1'b1);
    for (int k = 0; k < 10; k++) acc(1'b1, 3'h0, ENC_TAB[k], 32'h0000_1000);
    for (int k = 0; k < 10; k++) acc(1'b0, 3'h0, ENC_TAB[k], 32'h0);
    acc(1'b1, 3'h0, ENC_TAB[9], 32'h0000_0001);
    for (int k = 0; k < 10; k++) acc(1'b1, 3'h0, ENC_TAB[k], 32'h5A00_0000 + k);
    set_mode(`SSAG_MODE_MON);
    acc(1'b0, 3'h0, ENC_TAB[8], 32'h0);
    acc(1'b1, 3'h0, ENC_TAB[7], 32'h0000_7777);
    acc(1'b0, 3'h0, ENC_TAB[7], 32'h0);
    acc(1'b1, 3'h0, ENC_TAB[9], 32'h0000_0000);
    acc(1'b1, 3'h0, ENC_TAB[7], 32'h0000_8888);
    acc(1'b0, 3'h0, ENC_TAB[7], 32'h0);
    set_mode(`SSAG_MODE_USR);
    acc(1'b0, 3'h0, ENC_TAB[1], 32'h0);
    set_lock(1'b0);
    repeat (600) begin
      r = $urandom;
      if (r[2:0] == 3'h0)
        set_mode(r[4:3] == 2'h0 ? `SSAG_MODE_USR : r[4] ? `SSAG_MODE_MON : `SSAG_MODE_SVC);
      if (r[7:5] == 3'h0) set_lock(r[8]);
      acc(r[12], r[16:13] == 4'h0 ? r[19:17] : 3'h0,
          r[22:20] == 3'h0 ? 11'($urandom) : ENC_TAB[$urandom % 10], $urandom);
    end
    do_reset();
    acc(1'b0, 3'h0, ENC_TAB[0], 32'h0);
    print_verdict();
  end
endmodule
